/* verilog/iec_top.sv */
// Interrupt enable and acknowledge control of a two-wire bus unit.
// Assumes the flag events come from shifter logic on the same clock.
//
// Operation
// - Transmit-empty request needs flag and enable bit 7.
// - Transmit-end request at ninth rise, enable 6.
// - Clearing transmit-end flag or enable withdraws it.
// - Receive-full request gated by enable bit 5.
// - Clearing receive-full flag or enable withdraws it.
// - No-ack or arbitration lost request, enable 4.
// - Clearing no-ack, arbitration lost and overrun, or enable withdraws it.
// - Stop request only with enable bit 3.
// - Select 0 ignores received acknowledge bit.
// - Select 1 and ack 1 halts transfer.
// - Received ack captured read-only in bit 1.
// - Receiver sends bit 0 at ack time.
// - Transmit-end flag set at ninth rise or last bit.
// - No-ack flag set on missing ack, select 1.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`include "iec_defs.svh"
module iec_top (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [3:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [3:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    input  wire logic        SYNC_FMT,
    input  wire logic        TX_MODE,
    input  wire logic        EV_TX_EMPTY,
    input  wire logic        EV_NINTH_RISE,
    input  wire logic        EV_LAST_BIT,
    input  wire logic        EV_RX_LOAD,
    input  wire logic        EV_ACK_SAMPLE,
    input  wire logic        ACK_IN,
    input  wire logic        EV_ARB_LOST,
    input  wire logic        EV_OVERRUN,
    input  wire logic        EV_STOP,
    input  wire logic        TXDATA_WR,
    input  wire logic        RXDATA_RD,
    output logic             TX_EMPTY_IRQ,
    output logic             TX_DONE_IRQ,
    output logic             RX_FULL_IRQ,
    output logic             NO_ACK_IRQ,
    output logic             ERROR_IRQ,
    output logic             STOP_IRQ,
    output logic             ACK_OUT,
    output logic             XFER_HALT,
    output logic             IRQ
);
    logic [7:0]         ctrl;      // Enable and acknowledge control.
    logic [7:0]         stat;      // Bus status flags, bit 0 unused.
    logic [7:0]         stat_set;  // Hardware set terms per flag.
    logic [7:0]         stat_clr;  // Software clear terms per flag.
    logic [4:0]         pend;      // Sticky event bits.
    logic [4:0]         mask;      // Event mask, 1 lets a bit through.
    logic [4:0]         ev;        // Events feeding the sticky bits.
    logic [3:0]         aw_addr;   // Held write address.
    logic [7:0]         w_data;    // Held low byte of write data.
    logic               w_lane;    // Held strobe of the low byte.
    logic               aw_have;   // Write address is held.
    logic               w_have;    // Write data is held.
    logic               do_write;  // Register write happens now.
    logic               rd_take;   // Read address taken now.
    logic               rd_pend;   // This read clears the sticky bits.
    logic               ack_tx_sample; // Ack from a receiver sampled.
    iec_pkg::iec_wstate_t wstate;  // Write channel progress.

    // A write lands once address and data are both held and the low byte strobe is set.
    assign do_write = (wstate == iec_pkg::WR_IDLE) && aw_have && w_have && w_lane;
    assign rd_take  = ARVALID && ARREADY;
    assign rd_pend  = rd_take && (ARADDR == `IEC_OFF_PEND);
    assign ack_tx_sample = EV_ACK_SAMPLE && TX_MODE;

    // Write channel: address and data are taken in either order.
    always_ff @(posedge CLK) begin
        if (RST) begin
            AWREADY <= 1'b0;
            WREADY  <= 1'b0;
            BVALID  <= 1'b0;
            BRESP   <= `IEC_RESP_OK;
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 8'h00;
            w_lane  <= 1'b0;
            wstate  <= iec_pkg::WR_IDLE;
        end else begin
            case (wstate)
                iec_pkg::WR_IDLE: begin
                    // Ready is lowered on the take so one beat only is held.
                    if (AWVALID && AWREADY) begin
                        aw_addr <= AWADDR;
                        aw_have <= 1'b1;
                        AWREADY <= 1'b0;
                    end else if (!aw_have) begin
                        AWREADY <= 1'b1;
                    end
                    if (WVALID && WREADY) begin
                        w_data <= WDATA[7:0];
                        w_lane <= WSTRB[0];
                        w_have <= 1'b1;
                        WREADY <= 1'b0;
                    end else if (!w_have) begin
                        WREADY <= 1'b1;
                    end
                    // Both halves held: answer, error if unmapped.
                    if (aw_have && w_have) begin
                        BVALID <= 1'b1;
                        BRESP  <= (aw_addr == `IEC_OFF_CTRL || aw_addr == `IEC_OFF_STAT ||
                                   aw_addr == `IEC_OFF_PEND || aw_addr == `IEC_OFF_MASK)
                                  ? `IEC_RESP_OK : `IEC_RESP_ERR;
                        wstate <= iec_pkg::WR_RESP;
                    end
                end
                iec_pkg::WR_RESP: begin
                    // The response stands until the master takes it.
                    if (BREADY) begin
                        BVALID  <= 1'b0;
                        aw_have <= 1'b0;
                        w_have  <= 1'b0;
                        wstate  <= iec_pkg::WR_IDLE;
                    end
                end
                default: begin
                    wstate <= iec_pkg::WR_IDLE;
                end
            endcase
        end
    end

    // Read channel: one read at a time, data registered on the take.
    always_ff @(posedge CLK) begin
        if (RST) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= `IEC_RESP_OK;
        end else if (rd_take) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RRESP   <= `IEC_RESP_OK;
            case (ARADDR)
                `IEC_OFF_CTRL: RDATA <= {24'h000000, ctrl};
                `IEC_OFF_STAT: RDATA <= {24'h000000, stat};
                `IEC_OFF_PEND: RDATA <= {27'h0000000, pend};
                `IEC_OFF_MASK: RDATA <= {27'h0000000, mask};
                default: begin
                    RDATA <= 32'h0000_0000;
                    RRESP <= `IEC_RESP_ERR;
                end
            endcase
        end else if (RVALID) begin
            // Hold data until the master accepts it.
            if (RREADY) begin
                RVALID  <= 1'b0;
                ARREADY <= 1'b1;
            end
        end else begin
            ARREADY <= 1'b1;
        end
    end

    // Control register; the received ack bit ignores software writes.
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl <= `IEC_CTRL_RST;
        end else begin
            if (do_write && aw_addr == `IEC_OFF_CTRL) begin
                ctrl <= (w_data & `IEC_CTRL_WMASK) | (ctrl & ~`IEC_CTRL_WMASK);
            end
            if (ack_tx_sample) begin
                ctrl[`IEC_ACK_RX] <= ACK_IN;
            end
        end
    end

    // Hardware set terms of the status flags.
    always_comb begin
        stat_set = 8'h00;
        stat_set[`IEC_F_TXE] = EV_TX_EMPTY;
        stat_set[`IEC_F_TXD] = (EV_NINTH_RISE && !SYNC_FMT && stat[`IEC_F_TXE])
                             || (EV_LAST_BIT && SYNC_FMT);
        stat_set[`IEC_F_RXF] = EV_RX_LOAD;
        stat_set[`IEC_F_NAK] = ack_tx_sample && ACK_IN && ctrl[`IEC_ACK_SEL];
        stat_set[`IEC_F_STP] = EV_STOP;
        stat_set[`IEC_F_ARB] = EV_ARB_LOST;
        stat_set[`IEC_F_OVR] = EV_OVERRUN;
    end

    // Software clear terms: a written 0 clears, data port access too.
    always_comb begin
        stat_clr = 8'h00;
        if (do_write && aw_addr == `IEC_OFF_STAT) begin
            stat_clr = ~w_data & `IEC_STAT_MASK;
        end
        if (TXDATA_WR) begin
            stat_clr[`IEC_F_TXE] = 1'b1;
            stat_clr[`IEC_F_TXD] = 1'b1;
        end
        if (RXDATA_RD) begin
            stat_clr[`IEC_F_RXF] = 1'b1;
        end
    end

    // Status flags; a set in the clearing cycle wins over the clear.
    always_ff @(posedge CLK) begin
        if (RST) begin
            stat <= `IEC_STAT_RST;
        end else begin
            stat <= (stat_set | (stat & ~stat_clr)) & `IEC_STAT_MASK;
        end
    end

    // Sticky events: end, receive, no-ack, stop, error.
    assign ev = {stat_set[`IEC_F_TXD], stat_set[`IEC_F_RXF], stat_set[`IEC_F_NAK],
                 stat_set[`IEC_F_STP], stat_set[`IEC_F_ARB] | stat_set[`IEC_F_OVR]};

    // A read of the sticky register clears it; new events still land.
    always_ff @(posedge CLK) begin
        if (RST) begin
            pend <= `IEC_PEND_RST;
        end else begin
            pend <= (rd_pend ? `IEC_PEND_RST : pend) | ev;
        end
    end

    // Mask register of the same layout as the sticky bits.
    always_ff @(posedge CLK) begin
        if (RST) begin
            mask <= `IEC_PEND_RST;
        end else if (do_write && aw_addr == `IEC_OFF_MASK) begin
            mask <= w_data[4:0];
        end
    end

    // Request outputs other than IRQ are registered levels of flags and enables, with SYNC_FMT gating the overrun term of NO_ACK_IRQ and ERROR_IRQ.
    // Withdrawal follows a flag or enable clear one cycle later.
    always_ff @(posedge CLK) begin
        if (RST) begin
            TX_EMPTY_IRQ <= 1'b0;
            TX_DONE_IRQ  <= 1'b0;
            RX_FULL_IRQ  <= 1'b0;
            NO_ACK_IRQ   <= 1'b0;
            ERROR_IRQ    <= 1'b0;
            STOP_IRQ     <= 1'b0;
            IRQ          <= 1'b0;
        end else begin
            TX_EMPTY_IRQ <= stat[`IEC_F_TXE] && ctrl[`IEC_TXE_EN];
            TX_DONE_IRQ  <= stat[`IEC_F_TXD] && ctrl[`IEC_TXD_EN];
            RX_FULL_IRQ  <= stat[`IEC_F_RXF] && ctrl[`IEC_RXF_EN];
            NO_ACK_IRQ   <= ctrl[`IEC_NAK_EN] && (stat[`IEC_F_NAK] || stat[`IEC_F_ARB]
                            || (SYNC_FMT && stat[`IEC_F_OVR]));
            ERROR_IRQ    <= SYNC_FMT && stat[`IEC_F_OVR]
                            && (ctrl[`IEC_RXF_EN] || ctrl[`IEC_NAK_EN]);
            STOP_IRQ     <= stat[`IEC_F_STP] && ctrl[`IEC_STP_EN];
            IRQ          <= |(pend & mask);
        end
    end

    // Acknowledge drive and halt decision for the shifter.
    always_ff @(posedge CLK) begin
        if (RST) begin
            ACK_OUT   <= 1'b0;
            XFER_HALT <= 1'b0;
        end else begin
            ACK_OUT   <= ctrl[`IEC_ACK_TX];
            XFER_HALT <= ctrl[`IEC_ACK_SEL] && ctrl[`IEC_ACK_RX];
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_txe_irq: assert property (TX_EMPTY_IRQ == $past(stat[7] && ctrl[7]))
        else $error("transmit empty request wrong");
    a_txd_irq: assert property (stat_set[6] && ctrl[6] ##1 ctrl[6] |=> TX_DONE_IRQ)
        else $error("transmit end request missing");
    a_txd_drop: assert property (!stat[6] || !ctrl[6] |=> !TX_DONE_IRQ)
        else $error("transmit end request not withdrawn");
    a_rxf_irq: assert property (EV_RX_LOAD && ctrl[5] ##1 ctrl[5] |=> RX_FULL_IRQ)
        else $error("receive full request missing");
    a_rxf_drop: assert property (!stat[5] || !ctrl[5] |=> !RX_FULL_IRQ)
        else $error("receive full request not withdrawn");
    a_nak_irq: assert property (ctrl[4] && stat[2] |=> NO_ACK_IRQ)
        else $error("no ack request missing");
    a_nak_drop: assert property (!ctrl[4] |=> !NO_ACK_IRQ)
        else $error("no ack request not withdrawn");
    a_stop_gate: assert property (!ctrl[3] |=> !STOP_IRQ)
        else $error("stop request while disabled");
    a_no_halt: assert property (!ctrl[2] |=> !XFER_HALT)
        else $error("halt with judgement off");
    a_halt_set: assert property (ctrl[2] && ctrl[1] |=> XFER_HALT)
        else $error("halt missing");
    a_ack_ro: assert property (!$past(ack_tx_sample) |-> ctrl[1] == $past(ctrl[1]))
        else $error("received ack bit changed");
    a_ack_out: assert property (ACK_OUT == $past(ctrl[0]))
        else $error("sent ack bit wrong");
    a_txd_set: assert property (EV_LAST_BIT && SYNC_FMT |=> stat[6])
        else $error("transmit end flag not set");
    a_nak_set: assert property (ack_tx_sample && ACK_IN && ctrl[2] |=> stat[4])
        else $error("no ack flag not set");
    a_rst_ctrl: assert property ($past(RST) |-> ctrl == 8'h00 && !IRQ)
        else $error("enables not cleared by reset");

    c_write: cover property (BVALID && BREADY);
    c_txd: cover property (TX_DONE_IRQ ##1 !TX_DONE_IRQ);
    c_halt: cover property (XFER_HALT);
    c_irq: cover property (IRQ ##[1:20] !IRQ);
endmodule // iec_top

/* verilog/iec_defs.svh */
// Register offsets, bit positions, reset values and codes for the
// interrupt enable and acknowledge control block.
// Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
`ifndef IEC_DEFS_SVH
`define IEC_DEFS_SVH
// Byte offsets of the registers.
`define IEC_OFF_CTRL   4'h0
`define IEC_OFF_STAT   4'h4
`define IEC_OFF_PEND   4'h8
`define IEC_OFF_MASK   4'hC
// Bits of the enable and acknowledge control register.
`define IEC_TXE_EN     7
`define IEC_TXD_EN     6
`define IEC_RXF_EN     5
`define IEC_NAK_EN     4
`define IEC_STP_EN     3
`define IEC_ACK_SEL    2
`define IEC_ACK_RX     1
`define IEC_ACK_TX     0
// Bits of the bus status register.
`define IEC_F_TXE      7
`define IEC_F_TXD      6
`define IEC_F_RXF      5
`define IEC_F_NAK      4
`define IEC_F_STP      3
`define IEC_F_ARB      2
`define IEC_F_OVR      1
// Writable bits of the control register and of the status register.
`define IEC_CTRL_WMASK 8'hFD
`define IEC_STAT_MASK  8'hFE
// Reset values.
`define IEC_CTRL_RST   8'h00
`define IEC_STAT_RST   8'h00
`define IEC_PEND_RST   5'h00
// Bus response codes.
`define IEC_RESP_OK    2'h0
`define IEC_RESP_ERR   2'h2
`endif

/* verilog/iec_pkg.sv */
// Types shared by the interrupt enable and acknowledge control block.
// Assumes nothing of its surroundings.
package iec_pkg;
    // Write channel progress of the register slave.
    typedef enum {WR_IDLE, WR_RESP} iec_wstate_t;
endpackage

/* tb/iec_shift_model.sv */
// Model of the shifter that feeds event pulses to the control block.
// Assumes the same clock as the block; one event kind per request.
module iec_shift_model (
    input  wire logic       CLK,
    input  wire logic       GO,
    input  wire logic [2:0] KIND,
    input  wire logic       ACK,
    output logic            EV_TX_EMPTY,
    output logic            EV_NINTH_RISE,
    output logic            EV_LAST_BIT,
    output logic            EV_RX_LOAD,
    output logic            EV_ACK_SAMPLE,
    output logic            ACK_IN,
    output logic            EV_ARB_LOST,
    output logic            EV_OVERRUN,
    output logic            EV_STOP
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ninth_due;  // The ninth rise follows the transmit-empty pulse by one cycle.
    // Each event is a single-cycle pulse.
    always_ff @(posedge CLK) begin
        EV_TX_EMPTY   <= GO && KIND == 3'h0 || GO && KIND == 3'h1;
        ninth_due     <= GO && KIND == 3'h1;
        EV_NINTH_RISE <= ninth_due;
        EV_RX_LOAD    <= GO && KIND == 3'h2;
        EV_ACK_SAMPLE <= GO && KIND == 3'h3;
        EV_ARB_LOST   <= GO && KIND == 3'h4;
        EV_OVERRUN    <= GO && KIND == 3'h5;
        EV_STOP       <= GO && KIND == 3'h6;
        EV_LAST_BIT   <= GO && KIND == 3'h7;
        // The ack line shows the inverse outside its sample slot.
        ACK_IN        <= (GO && KIND == 3'h3) ? ACK : !ACK;
    end
endmodule // iec_shift_model

/* tb/i2c_irq_enable_ack_control_tb.sv */
// Self-checking bench of the interrupt enable and acknowledge block.
// Assumes the register map and latencies of the control block.
`include "iec_defs.svh"
module i2c_irq_enable_ack_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0;
    logic ARVALID = 0, RREADY = 0, SYNC_FMT = 0, TX_MODE = 1;
    logic TXDATA_WR = 0, RXDATA_RD = 0, GO = 0, ACK = 0;
    logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'hF;
    logic [2:0] KIND = 3'h0;
    logic [31:0] WDATA = 32'h0, RDATA, rd_v;
    logic [1:0] BRESP, RRESP, rsp;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, ACK_OUT, XFER_HALT, IRQ;
    logic TX_EMPTY_IRQ, TX_DONE_IRQ, RX_FULL_IRQ, NO_ACK_IRQ, ERROR_IRQ, STOP_IRQ;
    logic e_te, e_nr, e_lb, e_rl, e_as, e_ai, e_arb, e_ov, e_st;
    int err_count = 0, n_compared = 0;
    // Rows: control value, event kind, format, expected request levels.
    logic [17:0] rows [15] = '{
        {8'h80, 3'h0, 1'h0, 6'h20}, {8'h00, 3'h0, 1'h0, 6'h00},
        {8'h40, 3'h1, 1'h0, 6'h10}, {8'hC0, 3'h1, 1'h0, 6'h30},
        {8'h20, 3'h2, 1'h0, 6'h08}, {8'h00, 3'h2, 1'h0, 6'h00},
        {8'h14, 3'h3, 1'h0, 6'h04}, {8'h04, 3'h3, 1'h0, 6'h00},
        {8'h10, 3'h4, 1'h0, 6'h04}, {8'h20, 3'h5, 1'h1, 6'h02},
        {8'h10, 3'h5, 1'h1, 6'h06}, {8'h10, 3'h5, 1'h0, 6'h00},
        {8'h08, 3'h6, 1'h0, 6'h01}, {8'h00, 3'h6, 1'h0, 6'h00},
        {8'h40, 3'h7, 1'h1, 6'h10}};
    wire [5:0] irqs = {TX_EMPTY_IRQ, TX_DONE_IRQ, RX_FULL_IRQ, NO_ACK_IRQ,
                       ERROR_IRQ, STOP_IRQ};
    always #4 CLK = !CLK;
    iec_top dut (.CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .SYNC_FMT(SYNC_FMT),
        .TX_MODE(TX_MODE), .EV_TX_EMPTY(e_te), .EV_NINTH_RISE(e_nr),
        .EV_LAST_BIT(e_lb), .EV_RX_LOAD(e_rl), .EV_ACK_SAMPLE(e_as),
        .ACK_IN(e_ai), .EV_ARB_LOST(e_arb), .EV_OVERRUN(e_ov), .EV_STOP(e_st),
        .TXDATA_WR(TXDATA_WR), .RXDATA_RD(RXDATA_RD),
        .TX_EMPTY_IRQ(TX_EMPTY_IRQ), .TX_DONE_IRQ(TX_DONE_IRQ),
        .RX_FULL_IRQ(RX_FULL_IRQ), .NO_ACK_IRQ(NO_ACK_IRQ),
        .ERROR_IRQ(ERROR_IRQ), .STOP_IRQ(STOP_IRQ), .ACK_OUT(ACK_OUT),
        .XFER_HALT(XFER_HALT), .IRQ(IRQ));
    iec_shift_model pm (.CLK(CLK), .GO(GO), .KIND(KIND), .ACK(ACK),
        .EV_TX_EMPTY(e_te), .EV_NINTH_RISE(e_nr), .EV_LAST_BIT(e_lb),
        .EV_RX_LOAD(e_rl), .EV_ACK_SAMPLE(e_as), .ACK_IN(e_ai),
        .EV_ARB_LOST(e_arb), .EV_OVERRUN(e_ov), .EV_STOP(e_st));
    // Counts every compare and reports a mismatch at once.
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic close_out();
        $display("errors %0d compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Write: both channels offered, each dropped at its own ready edge.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        AWADDR <= a; WDATA <= {24'h0, d}; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
        do begin
            @(posedge CLK);
            if (AWREADY === 1'b1) AWVALID <= 0;
            if (WREADY === 1'b1) WVALID <= 0;
            n++;
        end while (BVALID !== 1'b1 && n < 50);
        // Ready stays high between writes, so no edge sees it toggled twice.
        rsp = BRESP;
        if (n >= 50) err_count++;
    endtask
    // Read: data and response are taken at the edge that shows RVALID.
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        int n;
        n = 0;
        ARADDR <= a; ARVALID <= 1; RREADY <= 1;
        do begin
            @(posedge CLK);
            if (ARREADY === 1'b1) ARVALID <= 0;
            n++;
        end while (RVALID !== 1'b1 && n < 50);
        d = RDATA; rsp = RRESP;
        if (n >= 50) err_count++;
    endtask
    // Asks the shifter model for one event, then lets the flags settle.
    task automatic ev(input logic [2:0] k);
        GO <= 1; KIND <= k;
        @(posedge CLK) GO <= 0;
        repeat (6) @(posedge CLK);
    endtask
    initial begin
        repeat (20000) @(posedge CLK);
        err_count++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge CLK);
        RST <= 0;
        @(posedge CLK);
        rd(`IEC_OFF_CTRL, rd_v); chk(rd_v, 32'h0);
        rd(`IEC_OFF_STAT, rd_v); chk(rd_v, 32'h0);
        chk({26'h0, irqs}, 32'h0);
        wr(`IEC_OFF_CTRL, 8'hFF); rd(`IEC_OFF_CTRL, rd_v); chk(rd_v, 32'hFD);
        chk({31'h0, ACK_OUT}, 32'h1);
        wr(`IEC_OFF_CTRL, 8'h00); @(posedge CLK);
        chk({31'h0, ACK_OUT}, 32'h0);
        ACK <= 1;
        foreach (rows[i]) begin
            SYNC_FMT <= rows[i][6];
            wr(`IEC_OFF_CTRL, rows[i][17:10]);
            ev(rows[i][9:7]);
            chk({26'h0, irqs}, {26'h0, rows[i][5:0]});
            wr(`IEC_OFF_STAT, 8'h00);
            repeat (2) @(posedge CLK);
            chk({26'h0, irqs}, 32'h0);
            rd(`IEC_OFF_PEND, rd_v);
        end
        SYNC_FMT <= 0; ACK <= 0;
        wr(`IEC_OFF_CTRL, 8'h00); ev(3'h3);
        rd(`IEC_OFF_CTRL, rd_v); chk(rd_v, 32'h0);
        ACK <= 1; ev(3'h3);
        rd(`IEC_OFF_CTRL, rd_v); chk(rd_v, 32'h2);
        chk({31'h0, XFER_HALT}, 32'h0);
        rd(`IEC_OFF_STAT, rd_v); chk(rd_v & 32'h10, 32'h0);
        wr(`IEC_OFF_CTRL, 8'h04); @(posedge CLK);
        chk({31'h0, XFER_HALT}, 32'h1);
        wr(`IEC_OFF_CTRL, 8'h40); ev(3'h1); chk({31'h0, TX_DONE_IRQ}, 32'h1);
        wr(`IEC_OFF_CTRL, 8'h00); @(posedge CLK);
        chk({31'h0, TX_DONE_IRQ}, 32'h0);
        // Transmit data write clears both transmit flags.
        wr(`IEC_OFF_CTRL, 8'hC0); @(posedge CLK);
        chk({26'h0, irqs}, 32'h30);
        TXDATA_WR <= 1; @(posedge CLK) TXDATA_WR <= 0; repeat (2) @(posedge CLK);
        chk({26'h0, irqs}, 32'h0);
        wr(`IEC_OFF_CTRL, 8'h20); ev(3'h2);
        chk({31'h0, RX_FULL_IRQ}, 32'h1);
        RXDATA_RD <= 1; @(posedge CLK) RXDATA_RD <= 0; repeat (2) @(posedge CLK);
        chk({31'h0, RX_FULL_IRQ}, 32'h0);
        // Sticky event, mask and read-to-clear of the pending register.
        rd(`IEC_OFF_PEND, rd_v); wr(`IEC_OFF_MASK, 8'h02); ev(3'h6);
        chk({31'h0, IRQ}, 32'h1);
        rd(`IEC_OFF_PEND, rd_v); chk(rd_v, 32'h2);
        @(posedge CLK); chk({31'h0, IRQ}, 32'h0);
        wr(`IEC_OFF_MASK, 8'h00); ev(3'h6); chk({31'h0, IRQ}, 32'h0);
        // Unaligned offset is unmapped and answers with an error.
        rd(4'h2, rd_v); chk({30'h0, rsp}, {30'h0, `IEC_RESP_ERR}); chk(rd_v, 32'h0);
        wr(4'h6, 8'hFF); chk({30'h0, rsp}, {30'h0, `IEC_RESP_ERR});
        TX_MODE <= 0; ACK <= 0; ev(3'h3);
        rd(`IEC_OFF_CTRL, rd_v); chk(rd_v & 32'h2, 32'h2);
        wr(`IEC_OFF_CTRL, 8'hFF); ev(3'h0);
        RST <= 1; repeat (2) @(posedge CLK);
        RST <= 0; @(posedge CLK);
        rd(`IEC_OFF_CTRL, rd_v); chk(rd_v, 32'h0);
        chk({24'h0, irqs, XFER_HALT, ACK_OUT}, 32'h0);
        close_out();
    end
endmodule // i2c_irq_enable_ack_control_tb
